// ---- hdl/mstb_unit.sv ----
// memory service unit: checksum engine and circular trace buffer writer
//
// Contract
// - checksum is reflected CRC32, polynomial edb88320, seeded from data register.
// - finished checksum stays uninverted in the data register.
// - under protection, checksum start forces address, length and data values.
// - checksum opcode starts the checksum; none opcode cancels a running one.
// - any other opcode during an operation aborts and reports cancelled.
// - outcome shows busy while running, done at end, unsupported if absent.
// - bus fault reports fault outcome, failing address left in address registers.
// - trace opcode makes the unit accept trace words.
// - circular buffer: insert pointer, tail pointer, upper bits form full address.
// - while storing, insert pointer is current address, length is bytes remaining.
// - at zero remaining, original pointer and length are restored.
// - buffer full when the insert pointer equals the tail register.
// - overwrite policy: keep going, set sticky wrap flag, request sync.
// - stop policy: full buffer returns to idle with done outcome.
// - halt-stall policy: request halt, stall the CPU until tail written.
// - halt-discard policy: request halt, drop words that do not fit.
// - any tail write, even unchanged, makes the whole buffer available.
// - after halt-discard resume, the first stored word is a sync message.
// - opcode 0 none, 1 checksum, 2 trace, others reserved.
// - policy 0 overwrite, 1 stop, 2 halt-stall, 3 halt-discard.
// - outcome 0 done,1 busy,2 unsupported,3 fault,4 failed,5 locked,6 cancelled.
// - upper register gives address bits 35:32, insert pointer bits 31:2.
`include "mstb_params.svh"

module mstb_unit #(
  parameter bit          HAS_CRC     = 1'b1,
  parameter bit          HAS_TRACE   = 1'b1,
  parameter logic [3:0]  PROT_UPPER  = 4'h0,
  parameter logic [29:0] PROT_INSERT = 30'h00000000,
  parameter logic [31:0] PROT_LENGTH = 32'h00010000,
  parameter logic [31:0] PROT_SEED   = 32'hffffffff
) (
  input  wire logic                 i_clock,      // core clock
  input  wire logic                 i_resetn,     // async reset, active low
  input  wire logic [2:0]           i_reg_addr,   // register index
  input  wire logic [31:0]          i_reg_wdata,  // register write data
  input  wire logic                 i_reg_wr,     // write strobe
  input  wire logic                 i_reg_rd,     // read strobe
  output logic [31:0]               o_reg_rdata,  // read data, next cycle
  input  wire logic                 i_protect,    // device protection active
  output mstb_pkg::mstb_bus_req_s   o_bus,        // system bus request
  input  wire mstb_pkg::mstb_bus_rsp_s i_bus,     // system bus response
  input  wire mstb_pkg::mstb_trace_s i_trace,     // trace word stream
  output logic                      o_trace_ready, // trace word accepted
  output logic                      o_sync_req,   // sync message request
  output logic                      o_halt_req,   // debug-mode entry request
  output logic                      o_cpu_stall   // hold the cpu
);

  // ============================================================
  // checksum of one word, lsb first
  function automatic logic [31:0] crc_word(input logic [31:0] crc,
                                           input logic [31:0] d);
    logic [31:0] c;
    c = crc;
    for (int i = 0; i < 32; i++) begin
      c = (c >> 1) ^ (`MSTB_CRC_POLY & {32{c[0] ^ d[i]}});
    end
    return c;
  endfunction

  // ============================================================
  // state
  mstb_pkg::mstb_state_s s;
  mstb_pkg::mstb_state_s next_s;

  logic        wr_ctrl;
  logic        wr_tail;
  logic [1:0]  wr_op;
  logic        busy;
  logic [29:0] adv_lo;
  logic [31:0] adv_len;
  logic        adv_wrap;

  assign wr_ctrl = i_reg_wr && (i_reg_addr == `MSTB_IDX_CTRL);
  assign wr_tail = i_reg_wr && (i_reg_addr == `MSTB_IDX_TAIL);
  assign wr_op   = i_reg_wdata[`MSTB_CTRL_OP_MSB:`MSTB_CTRL_OP_LSB];
  assign busy    = (s.fsm != mstb_pkg::ST_IDLE);

  // pointer advance for the trace engine, with wrap back to start
  always_comb begin
    adv_len  = s.length - `MSTB_WORD_BYTES;
    adv_wrap = (adv_len == 32'h00000000);
    adv_lo   = adv_wrap ? s.start_lo
                        : s.insert_pointer_reg + 30'h00000001;
    if (adv_wrap) begin
      adv_len = s.start_len;
    end
  end

  // ============================================================
  // next state
  always_comb begin
    next_s          = s;
    next_s.sync_req = 1'b0;
    next_s.halt_req = 1'b0;
    next_s.rdata    = 32'h00000000;

    // register reads
    if (i_reg_rd) begin
      if (i_reg_addr == `MSTB_IDX_UPPER) begin
        next_s.rdata = {28'h0000000, s.upper_address_reg};
      end else if (i_reg_addr == `MSTB_IDX_INSERT) begin
        next_s.rdata = {s.insert_pointer_reg, 2'h0};
      end else if (i_reg_addr == `MSTB_IDX_LENGTH) begin
        next_s.rdata = s.length;
      end else if (i_reg_addr == `MSTB_IDX_CTRL) begin
        next_s.rdata = {28'h0000000, s.policy, s.op};
      end else if (i_reg_addr == `MSTB_IDX_STATUS) begin
        next_s.rdata = {28'h0000000, s.wrap, s.result};
      end else if (i_reg_addr == `MSTB_IDX_DATA) begin
        next_s.rdata = s.data;
      end else if (i_reg_addr == `MSTB_IDX_TAIL) begin
        next_s.rdata = {s.tail, 2'h0};
      end else begin
        next_s.rdata = 32'h00000000;
      end
    end

    // register writes; engine-owned registers are frozen while busy
    if (i_reg_wr && !busy) begin
      if (i_reg_addr == `MSTB_IDX_UPPER) begin
        next_s.upper_address_reg = i_reg_wdata[`MSTB_UPPER_MSB:0];
      end else if (i_reg_addr == `MSTB_IDX_INSERT) begin
        next_s.insert_pointer_reg = i_reg_wdata[31:2];
      end else if (i_reg_addr == `MSTB_IDX_LENGTH) begin
        next_s.length = {i_reg_wdata[31:2], 2'h0};
      end else if (i_reg_addr == `MSTB_IDX_DATA) begin
        next_s.data = i_reg_wdata;
      end
    end
    if (wr_tail) begin
      next_s.tail = i_reg_wdata[31:2];
    end
    if (i_reg_wr && (i_reg_addr == `MSTB_IDX_STATUS) &&
        !i_reg_wdata[`MSTB_STAT_WRAP_BIT]) begin
      next_s.wrap = 1'b0;
    end

    // engines
    case (s.fsm)
      mstb_pkg::ST_IDLE: begin
        if (wr_ctrl) begin
          next_s.op     = wr_op;
          next_s.policy = i_reg_wdata[`MSTB_CTRL_POL_MSB:`MSTB_CTRL_POL_LSB];
          if (wr_op == `MSTB_OP_CHECKSUM) begin
            if (!HAS_CRC) begin
              next_s.result = `MSTB_RES_UNSUP;
              next_s.op     = `MSTB_OP_NONE;
            end else begin
              if (i_protect) begin
                next_s.upper_address_reg  = PROT_UPPER;
                next_s.insert_pointer_reg = PROT_INSERT;
                next_s.length             = PROT_LENGTH;
                next_s.data               = PROT_SEED;
              end
              next_s.result = `MSTB_RES_BUSY;
              if (next_s.length == 32'h00000000) begin
                next_s.result = `MSTB_RES_DONE;
                next_s.op     = `MSTB_OP_NONE;
              end else begin
                next_s.fsm       = mstb_pkg::ST_CRC;
                next_s.bus.req   = 1'b1;
                next_s.bus.we    = 1'b0;
                next_s.bus.addr  = {next_s.upper_address_reg,
                                    next_s.insert_pointer_reg, 2'h0};
              end
            end
          end else if (wr_op == `MSTB_OP_TRACE) begin
            if (!HAS_TRACE) begin
              next_s.result = `MSTB_RES_UNSUP;
              next_s.op     = `MSTB_OP_NONE;
            end else begin
              next_s.fsm         = mstb_pkg::ST_TR_WAIT;
              next_s.result      = `MSTB_RES_BUSY;
              next_s.start_lo    = s.insert_pointer_reg;
              next_s.start_len   = s.length;
              next_s.need_sync   = 1'b0;
              next_s.trace_ready = 1'b1;
            end
          end else if (wr_op != `MSTB_OP_NONE) begin
            next_s.result = `MSTB_RES_UNSUP;
            next_s.op     = `MSTB_OP_NONE;
          end
        end
      end

      mstb_pkg::ST_CRC: begin
        if (i_bus.err) begin
          // pointer still holds the failing word address
          next_s.bus.req = 1'b0;
          next_s.fsm     = mstb_pkg::ST_IDLE;
          next_s.result  = `MSTB_RES_BUSERR;
          next_s.op      = `MSTB_OP_NONE;
        end else if (i_bus.ack) begin
          next_s.data   = crc_word(s.data, i_bus.rdata);
          next_s.length = s.length - `MSTB_WORD_BYTES;
          if (s.length == `MSTB_WORD_BYTES) begin
            next_s.bus.req = 1'b0;
            next_s.fsm     = mstb_pkg::ST_IDLE;
            next_s.result  = `MSTB_RES_DONE;
            next_s.op      = `MSTB_OP_NONE;
          end else begin
            next_s.insert_pointer_reg = s.insert_pointer_reg +
                                        30'h00000001;
            next_s.bus.addr = {s.upper_address_reg,
                               next_s.insert_pointer_reg, 2'h0};
          end
        end
      end

      mstb_pkg::ST_TR_WAIT: begin
        if (i_trace.valid && s.trace_ready) begin
          if (s.need_sync && !i_trace.sync) begin
            next_s.trace_ready = 1'b1;
          end else begin
            next_s.need_sync   = 1'b0;
            next_s.trace_ready = 1'b0;
            next_s.fsm         = mstb_pkg::ST_TR_BUS;
            next_s.bus.req     = 1'b1;
            next_s.bus.we      = 1'b1;
            next_s.bus.addr    = {s.upper_address_reg,
                                  s.insert_pointer_reg, 2'h0};
            next_s.bus.wdata   = i_trace.data;
          end
        end
      end

      mstb_pkg::ST_TR_BUS: begin
        if (i_bus.err) begin
          next_s.bus.req = 1'b0;
          next_s.fsm     = mstb_pkg::ST_IDLE;
          next_s.result  = `MSTB_RES_BUSERR;
          next_s.op      = `MSTB_OP_NONE;
        end else if (i_bus.ack) begin
          next_s.bus.req     = 1'b0;
          next_s.insert_pointer_reg = adv_lo;
          next_s.length      = adv_len;
          next_s.fsm         = mstb_pkg::ST_TR_WAIT;
          next_s.trace_ready = 1'b1;
          if (adv_lo == s.tail) begin
            case (s.policy)
              `MSTB_POL_OVER: begin
                next_s.wrap     = 1'b1;
                next_s.sync_req = 1'b1;
              end
              `MSTB_POL_STOP: begin
                next_s.fsm         = mstb_pkg::ST_IDLE;
                next_s.result      = `MSTB_RES_DONE;
                next_s.op          = `MSTB_OP_NONE;
                next_s.trace_ready = 1'b0;
              end
              `MSTB_POL_HSTALL: begin
                next_s.fsm         = mstb_pkg::ST_TR_FULL;
                next_s.halt_req    = 1'b1;
                next_s.cpu_stall   = 1'b1;
                next_s.trace_ready = 1'b0;
              end
              default: begin
                // words are still taken so the cpu can reach debug mode
                next_s.fsm      = mstb_pkg::ST_TR_FULL;
                next_s.halt_req = 1'b1;
              end
            endcase
          end
        end
      end

      mstb_pkg::ST_TR_FULL: begin
        if (wr_tail) begin
          next_s.fsm         = mstb_pkg::ST_TR_WAIT;
          next_s.cpu_stall   = 1'b0;
          next_s.trace_ready = 1'b1;
          if (s.policy == `MSTB_POL_HDISC) begin
            next_s.need_sync = 1'b1;
            next_s.sync_req  = 1'b1;
          end
        end
      end

      default: begin
        next_s.fsm = mstb_pkg::ST_IDLE;
      end
    endcase

    // a different opcode aborts whatever runs; the bus request is dropped
    if (busy && wr_ctrl && (wr_op != s.op)) begin
      next_s.fsm         = mstb_pkg::ST_IDLE;
      next_s.result      = `MSTB_RES_CANCEL;
      next_s.op          = `MSTB_OP_NONE;
      next_s.bus.req     = 1'b0;
      next_s.trace_ready = 1'b0;
      next_s.cpu_stall   = 1'b0;
      next_s.need_sync   = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ============================================================
  // outputs
  assign o_reg_rdata   = s.rdata;
  assign o_bus         = s.bus;
  assign o_trace_ready = s.trace_ready;
  assign o_sync_req    = s.sync_req;
  assign o_halt_req    = s.halt_req;
  assign o_cpu_stall   = s.cpu_stall;

  // ============================================================
  // assertions
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  crc_update_a: assert property (
    (s.fsm == mstb_pkg::ST_CRC && i_bus.ack && !i_bus.err && !wr_ctrl)
    |=> s.data == crc_word($past(s.data), $past(i_bus.rdata)))
    else $error("checksum word update wrong");

  start_busy_a: assert property (
    (!busy && wr_ctrl && wr_op == `MSTB_OP_CHECKSUM && HAS_CRC &&
     (i_protect ? PROT_LENGTH : s.length) != 32'h00000000)
    |=> s.result == `MSTB_RES_BUSY && s.fsm == mstb_pkg::ST_CRC)
    else $error("checksum start did not report busy");

  protect_force_a: assert property (
    (!busy && wr_ctrl && wr_op == `MSTB_OP_CHECKSUM && HAS_CRC && i_protect)
    |=> s.insert_pointer_reg == PROT_INSERT && s.data == PROT_SEED &&
        s.length == PROT_LENGTH)
    else $error("protected checksum not forced");

  cancel_abort_a: assert property (
    (busy && wr_ctrl && wr_op != s.op)
    |=> s.fsm == mstb_pkg::ST_IDLE && s.result == `MSTB_RES_CANCEL &&
        !o_bus.req)
    else $error("cancel did not abort");

  fault_addr_a: assert property (
    (busy && o_bus.req && i_bus.err && !wr_ctrl)
    |=> s.result == `MSTB_RES_BUSERR &&
        {s.upper_address_reg, s.insert_pointer_reg} ==
        $past(o_bus.addr[35:2]))
    else $error("bus fault address not kept");

  trace_addr_a: assert property (
    (o_bus.req && o_bus.we) |-> o_bus.addr ==
    {s.upper_address_reg, s.insert_pointer_reg, 2'h0})
    else $error("trace write address wrong");

  wrap_restore_a: assert property (
    (s.fsm == mstb_pkg::ST_TR_BUS && i_bus.ack && !i_bus.err && !wr_ctrl &&
     s.length == `MSTB_WORD_BYTES)
    |=> s.insert_pointer_reg == s.start_lo && s.length == s.start_len)
    else $error("buffer end did not restore pointer");

  wrap_sticky_a: assert property (
    (s.wrap && !(i_reg_wr && i_reg_addr == `MSTB_IDX_STATUS)) |=> s.wrap)
    else $error("wrap flag lost");

  stop_done_a: assert property (
    (s.fsm == mstb_pkg::ST_TR_BUS && i_bus.ack && !i_bus.err && !wr_ctrl &&
     adv_lo == s.tail && s.policy == `MSTB_POL_STOP)
    |=> s.fsm == mstb_pkg::ST_IDLE && s.result == `MSTB_RES_DONE)
    else $error("stop policy did not finish");

  stall_hold_a: assert property (
    (s.cpu_stall && !wr_tail && !wr_ctrl) |=> s.cpu_stall && !o_trace_ready)
    else $error("stall released without tail write");

  sync_first_a: assert property (
    (s.need_sync && s.fsm == mstb_pkg::ST_TR_WAIT && i_trace.valid &&
     o_trace_ready && !i_trace.sync && !wr_ctrl)
    |=> s.fsm == mstb_pkg::ST_TR_WAIT && !o_bus.req)
    else $error("non-sync word stored after discard resume");

endmodule

// ---- hdl/mstb_params.svh ----
// constants for the memory service checksum and trace buffer block
`ifndef MSTB_PARAMS_SVH
`define MSTB_PARAMS_SVH

// ============================================================
// register indexes on the plain register port
`define MSTB_IDX_UPPER    3'h0
`define MSTB_IDX_INSERT   3'h1
`define MSTB_IDX_LENGTH   3'h2
`define MSTB_IDX_CTRL     3'h3
`define MSTB_IDX_STATUS   3'h4
`define MSTB_IDX_DATA     3'h5
`define MSTB_IDX_TAIL     3'h6

// ============================================================
// field positions
`define MSTB_CTRL_OP_LSB    0
`define MSTB_CTRL_OP_MSB    1
`define MSTB_CTRL_POL_LSB   2
`define MSTB_CTRL_POL_MSB   3
`define MSTB_STAT_RES_LSB   0
`define MSTB_STAT_RES_MSB   2
`define MSTB_STAT_WRAP_BIT  3
`define MSTB_UPPER_MSB      3

// ============================================================
// encodings
`define MSTB_OP_NONE      2'h0
`define MSTB_OP_CHECKSUM  2'h1
`define MSTB_OP_TRACE     2'h2
`define MSTB_POL_OVER     2'h0
`define MSTB_POL_STOP     2'h1
`define MSTB_POL_HSTALL   2'h2
`define MSTB_POL_HDISC    2'h3
`define MSTB_RES_DONE     3'h0
`define MSTB_RES_BUSY     3'h1
`define MSTB_RES_UNSUP    3'h2
`define MSTB_RES_BUSERR   3'h3
`define MSTB_RES_FAILED   3'h4
`define MSTB_RES_LOCKED   3'h5
`define MSTB_RES_CANCEL   3'h6

// ============================================================
// checksum and reset values
`define MSTB_CRC_POLY     32'hedb88320
`define MSTB_WORD_BYTES   32'h00000004
`define MSTB_RST_CTRL     4'h0
`define MSTB_RST_STATUS   4'h0
`define MSTB_RST_DATA     32'h00000000

`endif

// ---- hdl/mstb_pkg.sv ----
// types shared by the memory service checksum and trace buffer block
package mstb_pkg;

  // ============================================================
  // carriers
  typedef struct packed {
    logic        req;
    logic        we;
    logic [35:0] addr;
    logic [31:0] wdata;
  } mstb_bus_req_s;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } mstb_bus_rsp_s;

  typedef struct packed {
    logic        valid;
    logic        sync;
    logic [31:0] data;
  } mstb_trace_s;

  // ============================================================
  // state
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CRC,
    ST_TR_WAIT,
    ST_TR_BUS,
    ST_TR_FULL
  } mstb_fsm_e;

  typedef struct packed {
    mstb_fsm_e     fsm;
    logic [3:0]    upper_address_reg;
    logic [29:0]   insert_pointer_reg;
    logic [31:0]   length;
    logic [1:0]    op;
    logic [1:0]    policy;
    logic [2:0]    result;
    logic          wrap;
    logic [31:0]   data;
    logic [29:0]   tail;
    logic [29:0]   start_lo;
    logic [31:0]   start_len;
    logic          need_sync;
    mstb_bus_req_s bus;
    logic          trace_ready;
    logic          sync_req;
    logic          halt_req;
    logic          cpu_stall;
    logic [31:0]   rdata;
  } mstb_state_s;

endpackage

// ---- verif/mstb_mem_model.sv ----
// behavioural system bus memory that answers the unit's requests
module mstb_mem_model (
  input  wire logic                    i_clock,    // core clock
  input  wire logic                    i_resetn,   // async reset, active low
  input  wire mstb_pkg::mstb_bus_req_s i_req,      // request from the unit
  input  wire logic [3:0]              i_lat,      // wait cycles per answer
  input  wire logic [35:0]             i_err_addr, // address that faults
  output mstb_pkg::mstb_bus_rsp_s      o_rsp,      // answer to the unit
  output logic [31:0]                  o_wr_cnt,   // writes taken
  output logic [35:0]                  o_wr_addr,  // last write address
  output logic [31:0]                  o_wr_data   // last write data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt;
  // ============================================================
  // answer
  // read data is a pattern of the address; between answers it flips so
  // a unit that samples outside ack never sees a stale match
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rsp <= '0;
      wait_cnt <= 4'h0;
      o_wr_cnt <= 32'h0;
      o_wr_addr <= 36'h0;
      o_wr_data <= 32'h0;
    end else begin
      o_rsp.ack <= 1'b0;
      o_rsp.err <= 1'b0;
      o_rsp.rdata <= ~o_rsp.rdata;
      if (!i_req.req || o_rsp.ack || o_rsp.err) begin
        wait_cnt <= 4'h0;
      end else if (wait_cnt != i_lat) begin
        wait_cnt <= wait_cnt + 4'h1;
      end else if (i_req.addr == i_err_addr) begin
        o_rsp.err <= 1'b1;
      end else begin
        o_rsp.ack <= 1'b1;
        o_rsp.rdata <= i_req.addr[31:0] ^ 32'h3c5a0f96;
        if (i_req.we) begin
          o_wr_cnt <= o_wr_cnt + 32'h1;
          o_wr_addr <= i_req.addr;
          o_wr_data <= i_req.wdata;
        end
      end
    end
  end
endmodule

// ---- verif/tb.sv ----
// self-checking bench for the memory service unit
`include "mstb_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    clock;
  logic                    resetn;
  logic [2:0]              reg_addr;
  logic [31:0]             reg_wdata;
  logic                    reg_wr;
  logic                    reg_rd;
  logic [31:0]             reg_rdata;
  logic                    protect;
  mstb_pkg::mstb_bus_req_s bus_req;
  mstb_pkg::mstb_bus_rsp_s bus_rsp;
  mstb_pkg::mstb_trace_s   trace;
  logic                    trace_ready;
  logic                    sync_req;
  logic                    halt_req;
  logic                    cpu_stall;
  logic [3:0]              lat;
  logic [35:0]             err_addr;
  logic [31:0]             wr_cnt;
  logic [35:0]             wr_addr;
  logic [31:0]             wr_data;
  logic [31:0]             base;
  int                      n_mismatch;
  int                      tests_run;
  int                      n_sync;
  int                      n_halt;
  mstb_unit #(.PROT_INSERT(30'h00000010), .PROT_LENGTH(32'h00000008)) dut (
    .i_clock(clock), .i_resetn(resetn), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .o_reg_rdata(reg_rdata), .i_protect(protect), .o_bus(bus_req),
    .i_bus(bus_rsp), .i_trace(trace), .o_trace_ready(trace_ready),
    .o_sync_req(sync_req), .o_halt_req(halt_req), .o_cpu_stall(cpu_stall));
  mstb_mem_model mem (
    .i_clock(clock), .i_resetn(resetn), .i_req(bus_req), .i_lat(lat),
    .i_err_addr(err_addr), .o_rsp(bus_rsp), .o_wr_cnt(wr_cnt),
    .o_wr_addr(wr_addr), .o_wr_data(wr_data));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(negedge clock) begin
    if (sync_req === 1'b1) n_sync++;
    if (halt_req === 1'b1) n_halt++;
  end
  // ============================================================
  // helpers
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [2:0] a,
                      input logic [31:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk(what, e, reg_rdata);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 80; i++) begin
      @(negedge clock);
      if (dut.o_bus.req === 1'b0 && i > 2) return;
    end
    n_mismatch++;
    complete_run();
  endtask
  task automatic send(input logic s, input logic [31:0] d);
    @(posedge clock);
    trace <= '{valid: 1'b1, sync: s, data: d};
    // ready is only trusted once settled, never at the launching edge
    @(negedge clock);
    for (int i = 0; i < 40 && trace_ready !== 1'b1; i++) @(negedge clock);
    if (trace_ready !== 1'b1) begin
      n_mismatch++;
      complete_run();
    end
    @(posedge clock);
    trace.valid <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  task automatic start_trace(input logic [1:0] pol);
    wr(`MSTB_IDX_INSERT, 32'h200);
    wr(`MSTB_IDX_LENGTH, 32'hc);
    wr(`MSTB_IDX_TAIL, 32'h200);
    wr(`MSTB_IDX_CTRL, {28'h0, pol, `MSTB_OP_TRACE});
    base = wr_cnt;
  endtask
  function automatic logic [31:0] crc(input logic [31:0] c,
                                      input logic [31:0] a, input int n);
    logic [31:0] w;
    for (int k = 0; k < n; k++) begin
      w = (a + 32'(4 * k)) ^ 32'h3c5a0f96;
      for (int i = 0; i < 32; i++)
        c = (c[0] ^ w[i]) ? ((c >> 1) ^ `MSTB_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction
  // ============================================================
  // scenarios
  initial begin
    {resetn, reg_wr, reg_rd, protect, lat} = '0;
    reg_addr = 3'h0;
    reg_wdata = 32'h0;
    trace = '0;
    err_addr = '1;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    rchk("ctrl", `MSTB_IDX_CTRL, 32'h0);
    rchk("status", `MSTB_IDX_STATUS, 32'h0);
    rchk("unmapped", 3'h7, 32'h0);
    lat <= 4'h3;
    wr(`MSTB_IDX_INSERT, 32'h10);
    wr(`MSTB_IDX_LENGTH, 32'h10);
    wr(`MSTB_IDX_DATA, 32'hffffffff);
    wr(`MSTB_IDX_CTRL, `MSTB_OP_CHECKSUM);
    rchk("busy", `MSTB_IDX_STATUS, `MSTB_RES_BUSY);
    wait_idle();
    rchk("done", `MSTB_IDX_STATUS, `MSTB_RES_DONE);
    rchk("crc", `MSTB_IDX_DATA, crc(32'hffffffff, 32'h10, 4));
    lat <= 4'h0;
    err_addr <= 36'h18;
    // the finished checksum left length at zero: reload the range
    wr(`MSTB_IDX_INSERT, 32'h10);
    wr(`MSTB_IDX_LENGTH, 32'h10);
    wr(`MSTB_IDX_CTRL, `MSTB_OP_CHECKSUM);
    wait_idle();
    rchk("fault", `MSTB_IDX_STATUS, `MSTB_RES_BUSERR);
    rchk("fault addr", `MSTB_IDX_INSERT, 32'h18);
    err_addr <= '1;
    lat <= 4'hf;
    for (int k = 0; k < 2; k++) begin
      wr(`MSTB_IDX_CTRL, `MSTB_OP_CHECKSUM);
      wr(`MSTB_IDX_CTRL, k ? `MSTB_OP_NONE : `MSTB_OP_TRACE);
      rchk("cancel", `MSTB_IDX_STATUS, `MSTB_RES_CANCEL);
    end
    lat <= 4'h0;
    wr(`MSTB_IDX_CTRL, 32'h3);
    rchk("reserved op", `MSTB_IDX_STATUS, `MSTB_RES_UNSUP);
    @(posedge clock);
    protect <= 1'b1;
    wr(`MSTB_IDX_DATA, 32'h0);
    wr(`MSTB_IDX_CTRL, `MSTB_OP_CHECKSUM);
    wait_idle();
    @(posedge clock);
    protect <= 1'b0;
    rchk("prot crc", `MSTB_IDX_DATA, crc(32'hffffffff, 32'h40, 2));
    start_trace(`MSTB_POL_STOP);
    send(1'b0, 32'ha0);
    rchk("ptr", `MSTB_IDX_INSERT, 32'h204);
    rchk("left", `MSTB_IDX_LENGTH, 32'h8);
    send(1'b0, 32'ha1);
    send(1'b0, 32'ha2);
    chk("writes", base + 32'h3, wr_cnt);
    chk("waddr", 32'h208, wr_addr[31:0]);
    chk("wdata", 32'ha2, wr_data);
    rchk("ptr back", `MSTB_IDX_INSERT, 32'h200);
    rchk("len back", `MSTB_IDX_LENGTH, 32'hc);
    rchk("stopped", `MSTB_IDX_STATUS, `MSTB_RES_DONE);
    for (int p = 0; p < 4; p = p + ((p == 0) ? 2 : 1)) begin
      n_sync = 0;
      n_halt = 0;
      start_trace(p[1:0]);
      repeat (3) send(1'b0, 32'hb0);
      chk("halt", (p != 0) ? 32'h1 : 32'h0, n_halt);
      chk("stall", (p == 2) ? 32'h1 : 32'h0, 32'(cpu_stall));
      if (p == 0) begin
        chk("wsync", 32'h1, n_sync);
        rchk("wrap", `MSTB_IDX_STATUS, 32'h9);
        wr(`MSTB_IDX_STATUS, 32'h0);
        rchk("unwrap", `MSTB_IDX_STATUS, `MSTB_RES_BUSY);
        send(1'b0, 32'hb1);
        chk("keep on", base + 32'h4, wr_cnt);
      end else begin
        if (p == 3) send(1'b0, 32'hb2);
        chk("dropped", base + 32'h3, wr_cnt);
        wr(`MSTB_IDX_TAIL, 32'h200);
        @(negedge clock);
        chk("unstall", 32'h0, 32'(cpu_stall));
        if (p == 3) send(1'b0, 32'hb3);
        send(1'b1, 32'h5c);
        chk("resume", base + 32'h4, wr_cnt);
        chk("rsync", (p == 3) ? 32'h1 : 32'h0, n_sync);
      end
      wr(`MSTB_IDX_CTRL, `MSTB_OP_NONE);
    end
    complete_run();
  end
endmodule
